/* File: hw/charger_regs_map.vh */
// register offsets, field positions and reset values of the charger status and fault bank
`ifndef CHARGER_REGS_MAP_VH
`define CHARGER_REGS_MAP_VH

`define ADDR_CHARGER_STATUS_TWO 8'h0C
`define ADDR_FAULT_FLAGS 8'h0D
`define ADDR_BATTERY_SHORT_CONFIG 8'h10

`define ZONE_HI 7
`define ZONE_LO 5
`define RECHARGE_BIT 3
`define LEVEL_HI 2
`define LEVEL_LO 0

`define FAULT_SHORT_BIT 3
`define FAULT_TLOW_BIT 1
`define FAULT_THIGH_BIT 0
`define FAULT_USED_MASK 8'h0B

`define TIMEOUT_HI 7
`define TIMEOUT_LO 5
`define VSHORT_HI 2
`define VSHORT_LO 0
`define CONFIG_USED_MASK 8'hE7

`define CHARGE_COMPLETE 3'h4
`define TIMEOUT_RESET 3'h4
`define VSHORT_RESET 3'h4
`define FAULT_RESET 8'h00
`define BYTE_ZERO 8'h00
`define CODE_ZERO 3'h0

`define CODE_WIDTH 3
`define FLAG_WIDTH 1
`define FIELD_UPPER_HI 7
`define FIELD_UPPER_LO 5
`define FIELD_LOWER_HI 2
`define FIELD_LOWER_LO 0

`endif

/* File: hw/sync_two_stage.v */
// two flip-flop synchroniser for a group of asynchronous condition inputs
`timescale 1ns/1ns
`default_nettype none

module sync_two_stage #(
	parameter WIDTH = 14
) (
	input wire clk_in,
	input wire rst_b_in,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	// the first stage feeds only the second stage
	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule

`default_nettype wire

/* File: hw/charger_status_fault_regs.v */
// status, fault and battery-short configuration register bank of the charger
`timescale 1ns/1ns
`default_nettype none
`include "charger_regs_map.vh"

module charger_status_fault_regs (
	input wire clk_in,
	input wire rst_b_in,
	input wire [7:0] reg_addr_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [7:0] reg_wdata_in,
	output reg [7:0] reg_rdata_out,
	output reg reg_rvalid_out,
	input wire [2:0] thermistor_zone_code_in,
	input wire [2:0] battery_level_in,
	input wire [2:0] charge_state_in,
	input wire auto_recharge_disable_in,
	input wire below_recharge_threshold_in,
	input wire battery_short_detect_in,
	input wire thermal_fault_low_in,
	input wire thermal_fault_high_in,
	output reg [2:0] short_timeout_sel_out,
	output reg [2:0] short_voltage_sel_out
);
	wire [7:0] clear_mask;
	wire [2:0] zone_s;
	wire [2:0] level_s;
	wire [2:0] state_s;
	wire rch_dis_s;
	wire below_s;
	wire short_s;
	wire tlow_s;
	wire thigh_s;
	reg [7:0] fault_q;
	reg [7:0] fault_d;
	reg [7:0] config_d;
	reg [7:0] status_two;
	reg [7:0] rdata_d;
	wire fault_wr;
	wire config_wr;

	// one register address compared against the bus address
	function addr_hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			addr_hit = (addr == target);
		end
	endfunction

	// a detection in the same cycle as its write-one clear wins, so no event is lost
	function sticky_next;
		input flag;
		input set;
		input clear;
		begin
			sticky_next = set | (flag & ~clear);
		end
	endfunction

	// status and configuration bytes share the same two 3-bit field positions
	function [7:0] place_fields;
		input [2:0] upper;
		input [2:0] lower;
		begin
			place_fields = `BYTE_ZERO;
			place_fields[`FIELD_UPPER_HI:`FIELD_UPPER_LO] = upper;
			place_fields[`FIELD_LOWER_HI:`FIELD_LOWER_LO] = lower;
		end
	endfunction

	// outside its active window the flag reads zero
	function recharge_flag;
		input disabled;
		input [2:0] state;
		input below;
		begin
			recharge_flag = disabled && (state == `CHARGE_COMPLETE) && below;
		end
	endfunction

	// analog conditions pass two flops; a code caught mid-change may show one stray value for a cycle
	sync_two_stage #(
		.WIDTH(`CODE_WIDTH)
	) zone_sync (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.async_in(thermistor_zone_code_in),
		.sync_out(zone_s)
	);

	sync_two_stage #(
		.WIDTH(`CODE_WIDTH)
	) level_sync (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.async_in(battery_level_in),
		.sync_out(level_s)
	);

	sync_two_stage #(
		.WIDTH(`CODE_WIDTH)
	) state_sync (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.async_in(charge_state_in),
		.sync_out(state_s)
	);

	sync_two_stage #(
		.WIDTH(`FLAG_WIDTH)
	) recharge_off_sync (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.async_in(auto_recharge_disable_in),
		.sync_out(rch_dis_s)
	);

	sync_two_stage #(
		.WIDTH(`FLAG_WIDTH)
	) below_sync (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.async_in(below_recharge_threshold_in),
		.sync_out(below_s)
	);

	sync_two_stage #(
		.WIDTH(`FLAG_WIDTH)
	) short_sync (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.async_in(battery_short_detect_in),
		.sync_out(short_s)
	);

	sync_two_stage #(
		.WIDTH(`FLAG_WIDTH)
	) thermal_low_sync (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.async_in(thermal_fault_low_in),
		.sync_out(tlow_s)
	);

	sync_two_stage #(
		.WIDTH(`FLAG_WIDTH)
	) thermal_high_sync (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.async_in(thermal_fault_high_in),
		.sync_out(thigh_s)
	);

	assign fault_wr = reg_wr_in && addr_hit(reg_addr_in, `ADDR_FAULT_FLAGS);
	assign config_wr = reg_wr_in && addr_hit(reg_addr_in, `ADDR_BATTERY_SHORT_CONFIG);
	assign clear_mask = fault_wr ? (reg_wdata_in & `FAULT_USED_MASK) : `BYTE_ZERO;

	// unused fault bits start from zero and nothing ever sets them
	always @* begin
		fault_d = `FAULT_RESET;
		fault_d[`FAULT_SHORT_BIT] = sticky_next(fault_q[`FAULT_SHORT_BIT], short_s, clear_mask[`FAULT_SHORT_BIT]);
		fault_d[`FAULT_TLOW_BIT] = sticky_next(fault_q[`FAULT_TLOW_BIT], tlow_s, clear_mask[`FAULT_TLOW_BIT]);
		fault_d[`FAULT_THIGH_BIT] = sticky_next(fault_q[`FAULT_THIGH_BIT], thigh_s, clear_mask[`FAULT_THIGH_BIT]);
	end

	always @* begin
		config_d = place_fields(short_timeout_sel_out, short_voltage_sel_out);
	end

	always @* begin
		status_two = place_fields(zone_s, level_s);
		status_two[`RECHARGE_BIT] = recharge_flag(rch_dis_s, state_s, below_s);
	end

	always @* begin
		case (reg_addr_in)
			`ADDR_CHARGER_STATUS_TWO: begin
				rdata_d = status_two;
			end
			`ADDR_FAULT_FLAGS: begin
				rdata_d = fault_q & `FAULT_USED_MASK;
			end
			`ADDR_BATTERY_SHORT_CONFIG: begin
				rdata_d = config_d & `CONFIG_USED_MASK;
			end
			default: begin
				rdata_d = `BYTE_ZERO;
			end
		endcase
	end

	// power-on reset stands in for a supply cycle on the input pins
	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			fault_q <= `FAULT_RESET;
			short_timeout_sel_out <= `TIMEOUT_RESET;
			short_voltage_sel_out <= `VSHORT_RESET;
			reg_rdata_out <= `BYTE_ZERO;
			reg_rvalid_out <= 1'b0;
		end else begin
			fault_q <= fault_d;
			if (config_wr) begin
				short_timeout_sel_out <= reg_wdata_in[`TIMEOUT_HI:`TIMEOUT_LO];
				short_voltage_sel_out <= reg_wdata_in[`VSHORT_HI:`VSHORT_LO];
			end
			reg_rvalid_out <= reg_rd_in;
			if (reg_rd_in) begin
				reg_rdata_out <= rdata_d;
			end
		end
	end
endmodule

`default_nettype wire

/* File: verif/regs_props.sv */
// port checks of the charger register bank
`timescale 1ns/1ns
`default_nettype none
module regs_props (input wire logic clk_in, rst_b_in, reg_wr_in, reg_rd_in, reg_rvalid_out,
	input wire logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out,
	input wire logic [2:0] short_timeout_sel_out, short_voltage_sel_out);
	logic [7:0] p = 8'h00;
	wire logic w = reg_wr_in && reg_addr_in == 8'h10;
	wire logic [5:0] c = {short_timeout_sel_out, short_voltage_sel_out};
	// read data only counts in its answer cycle
	wire logic [7:0] r = reg_rvalid_out ? reg_rdata_out : 8'h00;
	default clocking @(posedge clk_in); endclocking
	// the edge after release still shows outputs moving from the reset edge
	logic rst_q = 1'b0;
	always @(posedge clk_in) rst_q <= rst_b_in;
	default disable iff (!rst_b_in || !rst_q);
	always @(posedge clk_in) p <= reg_addr_in;
	a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out) else $error("no answer");
	a_no_stray: assert property (!reg_rd_in |=> !reg_rvalid_out) else $error("stray answer");
	a_config_write: assert property (w |=> c == $past({reg_wdata_in[7:5], reg_wdata_in[2:0]}))
		else $error("cfg write");
	a_config_hold: assert property (!w |=> $stable(c)) else $error("cfg moved");
	a_config_read: assert property (reg_rvalid_out && p == 8'h10 |-> r == $past({c[5:3], 2'h0, c[2:0]}))
		else $error("cfg read");
	a_fault_unused: assert property (p == 8'h0D |-> (r & 8'hF4) == 8'h00) else $error("fault read");
	a_unmapped_zero: assert property (!(p inside {8'h0C, 8'h0D, 8'h10}) |-> r == 8'h00)
		else $error("unmapped");
endmodule
bind charger_status_fault_regs regs_props props (.*);
`default_nettype wire

/* File: verif/test_charger_status_fault_regs.sv */
// self-checking bench of the charger register bank
`timescale 1ns/1ns
`default_nettype none
module test_charger_status_fault_regs;
	logic clk_in = 0, rst_b_in = 0, reg_wr_in = 0, reg_rd_in = 0, reg_rvalid_out;
	logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
	logic [2:0] f = 3'h0, short_timeout_sel_out, short_voltage_sel_out;
	logic [10:0] s = 11'h000;
	int err_total = 0, checked = 0;
	charger_status_fault_regs DUT (.*, .thermistor_zone_code_in(s[10:8]), .battery_level_in(s[7:5]),
		.charge_state_in(s[4:2]), .auto_recharge_disable_in(s[1]), .below_recharge_threshold_in(s[0]),
		.battery_short_detect_in(f[2]), .thermal_fault_low_in(f[1]), .thermal_fault_high_in(f[0]));
	initial forever #5 clk_in = ~clk_in;
	initial begin
		#20000 err_total++;
		end_of_test;
	end
	task chk(input logic [8:0] sv, e);
		checked++;
		err_total += int'(sv !== e);
		if (sv !== e) $display("CHECK FAILED rdata exp %h seen %h", e, sv);
	endtask
	task wt(input logic [7:0] ad, dt);
		@(posedge clk_in) {reg_addr_in, reg_wdata_in, reg_wr_in} <= {ad, dt, 1'b1};
		@(posedge clk_in) reg_wr_in <= 0;
	endtask
	// three edges first so the condition synchroniser has settled
	task rdc(input logic [7:0] ad, e);
		repeat (3) @(posedge clk_in);
		{reg_addr_in, reg_rd_in} <= {ad, 1'b1};
		@(posedge clk_in) reg_rd_in <= 0;
		#1 chk({reg_rvalid_out, reg_rdata_out}, {1'b1, e});
	endtask
	task t_config;
		wt(8'h10, 8'h5A);
		rdc(8'h10, 8'h42);
		rdc(8'h0E, 8'h00);
	endtask
	task t_status;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_in) s <= {(i > 4) ? 3'h7 : 3'(i), 3'(i % 5), i[2] ? 3'h4 : 3'h5, i[0], i[1]};
			rdc(8'h0C, {(i > 4) ? 3'h7 : 3'(i), 1'b0, i == 7, 3'(i % 5)});
		end
	endtask
	task t_fault;
		@(posedge clk_in) f <= 3'h7;
		repeat (3) @(posedge clk_in);
		f <= 3'h0;
		rdc(8'h0D, 8'h0B);
		wt(8'h0D, 8'hF5);
		rdc(8'h0D, 8'h0A);
		// a one-cycle detection meets the write-one clear at the same edge: the detection wins
		@(posedge clk_in) f <= 3'h4;
		@(posedge clk_in) f <= 3'h0;
		wt(8'h0D, 8'h0A);
		rdc(8'h0D, 8'h08);
		@(posedge clk_in) rst_b_in <= 0;
		@(posedge clk_in) rst_b_in <= 1;
		rdc(8'h0D, 8'h00);
		rdc(8'h10, 8'h84);
	endtask
	initial begin
		repeat (5) @(posedge clk_in);
		rst_b_in <= 1;
		t_config;
		t_status;
		t_fault;
		end_of_test;
	end
	task end_of_test;
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
endmodule
`default_nettype wire
